// ### design/bdu_core.v
// Breakpoint debug unit: registers, cycle comparators and debug exception requests
// Summary of operation
// - Four breakpoint linear address registers compared against every cycle address.
// - Extension off: alias numbers 4 and 5 reach status and control.
// - Extension on: any access to alias numbers raises undefined-opcode.
// - Every matching breakpoint sets its match status bit, enabled or not.
// - Breakpoints with both enables clear never raise a debug exception.
// - Guard set and debug register access decoded: set bit 13, fault.
// - Single-step flag set: trap after each instruction, set bit 14.
// - Task switch to trap-flagged task sets bit 15 and traps.
// - Every task switch clears all four local enables.
// - Global enables survive task switches and alone enable a breakpoint.
// - Legacy exact bits 8 and 9 are stored only, no effect.
// - Guard bit 13 clears whenever any debug exception is raised.
// - Type field: exec, data write, I/O, data read or write.
// - Length field: one, two or four bytes; 10b undefined.
// - Data, I/O, step and task-switch events are vector 01h traps.
// - Execution breakpoints and access detect are vector 01h faults.
// - Opcode CCh raises a vector 03h trap after it executes.
`timescale 1ns/1ps
`default_nettype none
`include "bdu_map.vh"
module bdu_core #(
  parameter AW = 32
) (
  input wire mclk_i,
  input wire reset_i,
  // Register port
  input wire [2:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Core state
  input wire debug_extension_enable_i,
  input wire single_step_flag_i,
  // Instruction stream
  input wire insn_done_i,
  input wire [7:0] insn_opcode_i,
  input wire dbg_reg_access_i,
  input wire task_switch_i,
  input wire task_trap_flag_i,
  // Processor cycles
  input wire cyc_valid_i,
  input wire cyc_fetch_i,
  input wire cyc_write_i,
  input wire cyc_io_i,
  input wire [AW-1:0] cyc_addr_i,
  input wire [1:0] cyc_size_i,
  // Exception requests
  output reg exc_fault_o,
  output reg exc_trap_o,
  output reg [7:0] exc_vector_o,
  output reg exc_undef_o
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [31:0] status_ff;
  reg [31:0] control_ff;
  wire [4*AW-1:0] bp_addr_all;

  // Access decode with alias folding
  reg [2:0] eff_reg;
  reg alias_hit;
  always @* begin
    alias_hit = (reg_addr_i == `BDU_REG_ALIAS_ST) || (reg_addr_i == `BDU_REG_ALIAS_CT);
    eff_reg = reg_addr_i;
    if (reg_addr_i == `BDU_REG_ALIAS_ST) begin
      eff_reg = `BDU_REG_STATUS;
    end else if (reg_addr_i == `BDU_REG_ALIAS_CT) begin
      eff_reg = `BDU_REG_CONTROL;
    end
  end

  // An alias access with the extension on is refused outright
  wire acc_block = alias_hit && debug_extension_enable_i;
  wire wr_ok = reg_wr_i && !acc_block;
  wire rd_ok = reg_rd_i && !acc_block;
  wire bp_wr = wr_ok && (eff_reg[2] == 1'b0);

  // ------------------------------------------------------------
  // Breakpoint address storage
  // ------------------------------------------------------------
  bdu_addr_regs #(.WIDTH(32)) u_addr (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .wr_i(bp_wr),
    .wsel_i(eff_reg[1:0]),
    .wdata_i(reg_wdata_i),
    .rsel_i(eff_reg[1:0]),
    .rdata_o(), // The port reads the word outputs so its data leave from one flop
    .addr_all_o(bp_addr_all)
  );

  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  // Type and length fields of one breakpoint in the control word
  function [1:0] type_field;
    input [31:0] ctl;
    input integer idx;
    begin
      type_field = ctl[`BDU_CT_TYPE_LO + 4*idx +: 2];
    end
  endfunction

  function [1:0] len_field;
    input [31:0] ctl;
    input integer idx;
    begin
      len_field = ctl[`BDU_CT_TYPE_LO + 4*idx + 2 +: 2];
    end
  endfunction

  // Byte mask of an aligned breakpoint range inside its dword
  function [3:0] byte_mask;
    input [1:0] lo;
    input [1:0] len;
    begin
      case (len)
        `BDU_LEN_1: byte_mask = 4'h1 << lo;
        `BDU_LEN_2: byte_mask = lo[1] ? 4'hC : 4'h3;
        `BDU_LEN_4: byte_mask = 4'hF;
        default: byte_mask = 4'h0; // Undefined length never matches a data or I/O access; execution compares ignore length
      endcase
    end
  endfunction

  // Bytes a cycle touches in its own dword (low half) and the next one (high half);
  // the cycle size code uses the same encoding as the length field
  function [7:0] span_mask;
    input [1:0] lo;
    input [1:0] size;
    begin
      case (size)
        `BDU_LEN_1: span_mask = 8'h01 << lo;
        `BDU_LEN_2: span_mask = 8'h03 << lo;
        `BDU_LEN_4: span_mask = 8'h0F << lo;
        default: span_mask = 8'h00; // Undefined size touches nothing
      endcase
    end
  endfunction

  // A misaligned cycle may spill into the next dword, so both halves are compared
  function range_hit;
    input [AW-1:0] ca;
    input [1:0] cs;
    input [AW-1:0] ba;
    input [1:0] bl;
    reg [7:0] span;
    reg [3:0] bmask;
    reg [AW-3:0] next_dw;
    begin
      span = span_mask(ca[1:0], cs);
      bmask = byte_mask(ba[1:0], bl);
      next_dw = ca[AW-1:2] + {{(AW-3){1'b0}}, 1'b1};
      range_hit = ((ca[AW-1:2] == ba[AW-1:2]) && ((span[3:0] & bmask) != 4'h0)) ||
                  ((next_dw == ba[AW-1:2]) && ((span[7:4] & bmask) != 4'h0));
    end
  endfunction

  reg [3:0] hit;
  reg [1:0] bp_type;
  reg [1:0] bp_len;
  reg [AW-1:0] bp_addr;
  integer k;
  always @* begin
    hit = 4'h0;
    bp_type = 2'h0;
    bp_len = 2'h0;
    bp_addr = {AW{1'b0}};
    for (k = 0; k < 4; k = k + 1) begin
      bp_type = type_field(control_ff, k);
      bp_len = len_field(control_ff, k);
      bp_addr = bp_addr_all[AW*k +: AW];
      if (cyc_valid_i) begin
        case (bp_type)
          `BDU_TYPE_EXEC:
            hit[k] = cyc_fetch_i && (cyc_addr_i == bp_addr);
          `BDU_TYPE_WRITE:
            hit[k] = !cyc_fetch_i && !cyc_io_i && cyc_write_i &&
                     range_hit(cyc_addr_i, cyc_size_i, bp_addr, bp_len);
          `BDU_TYPE_IO:
            hit[k] = debug_extension_enable_i && cyc_io_i &&
                     range_hit(cyc_addr_i, cyc_size_i, bp_addr, bp_len);
          `BDU_TYPE_RDWR:
            hit[k] = !cyc_fetch_i && !cyc_io_i &&
                     range_hit(cyc_addr_i, cyc_size_i, bp_addr, bp_len);
          default: hit[k] = 1'b0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Event classification
  // ------------------------------------------------------------
  // Enabled by local or global bit; exact bits 8 and 9 are never read here
  wire [3:0] bp_en;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_en
      assign bp_en[g] = control_ff[2*g] | control_ff[2*g+1];
    end
  endgenerate

  reg [3:0] is_exec;
  integer m;
  always @* begin
    is_exec = 4'h0;
    for (m = 0; m < 4; m = m + 1) begin
      is_exec[m] = (type_field(control_ff, m) == `BDU_TYPE_EXEC);
    end
  end

  wire [3:0] hit_en = hit & bp_en;
  wire exec_fault = |(hit_en & is_exec);
  wire data_trap = |(hit_en & ~is_exec);
  // Guarded debug register access, taken before the access itself
  wire guard_fault = dbg_reg_access_i && control_ff[`BDU_CT_GUARD];
  wire step_trap = insn_done_i && single_step_flag_i;
  wire ts_trap = task_switch_i && task_trap_flag_i;
  wire brk_trap = insn_done_i && (insn_opcode_i == `BDU_OP_BREAK);

  wire any_fault = exec_fault || guard_fault;
  wire any_trap01 = data_trap || step_trap || ts_trap;
  wire any_debug = any_fault || any_trap01;

  // ------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle
  reg [31:0] nxt_status;
  always @* begin
    nxt_status = status_ff;
    if (wr_ok && eff_reg == `BDU_REG_STATUS) begin
      nxt_status = (reg_wdata_i & `BDU_STATUS_LIVE) | (`BDU_STATUS_RST & ~`BDU_STATUS_LIVE);
    end
    nxt_status[3:0] = nxt_status[3:0] | hit;
    if (guard_fault) begin
      nxt_status[`BDU_ST_BD] = 1'b1;
    end
    if (step_trap) begin
      nxt_status[`BDU_ST_BS] = 1'b1;
    end
    if (ts_trap) begin
      nxt_status[`BDU_ST_BT] = 1'b1;
    end
  end

  // Bits only drop through a software write, never on their own
  always @(posedge mclk_i) begin
    if (reset_i) begin
      status_ff <= `BDU_STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  reg [31:0] nxt_control;
  integer j;
  always @* begin
    nxt_control = control_ff;
    if (wr_ok && eff_reg == `BDU_REG_CONTROL) begin
      nxt_control = (reg_wdata_i & `BDU_CONTROL_LIVE) | (`BDU_CONTROL_RST & ~`BDU_CONTROL_LIVE);
    end
    if (task_switch_i) begin
      for (j = 0; j < 4; j = j + 1) begin
        nxt_control[2*j] = 1'b0;
      end
    end
    // Guard drops so the debugger can reach the registers itself
    if (any_debug) begin
      nxt_control[`BDU_CT_GUARD] = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      control_ff <= `BDU_CONTROL_RST;
    end else begin
      control_ff <= nxt_control;
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  // Every source is a register already, so one port flop gives the one-cycle answer
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h00000000;
    if (rd_ok) begin
      case (eff_reg)
        `BDU_REG_STATUS: nxt_rdata = status_ff;
        `BDU_REG_CONTROL: nxt_rdata = control_ff;
        default: nxt_rdata = bp_addr_all[AW*eff_reg[1:0] +: 32];
      endcase
    end
  end

  // A refused or absent read returns zero
  always @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // Exception requests, one cycle after the cause
  // ------------------------------------------------------------
  // Faults take priority since they precede the instruction
  always @(posedge mclk_i) begin
    if (reset_i) begin
      exc_fault_o <= 1'b0;
      exc_trap_o <= 1'b0;
      exc_vector_o <= 8'h00;
      exc_undef_o <= 1'b0;
    end else begin
      exc_fault_o <= any_fault;
      exc_trap_o <= !any_fault && (any_trap01 || brk_trap);
      exc_undef_o <= acc_block && (reg_rd_i || reg_wr_i);
      if (any_debug) begin
        exc_vector_o <= `BDU_VEC_DEBUG;
      end else if (brk_trap) begin
        exc_vector_o <= `BDU_VEC_BREAK;
      end else begin
        exc_vector_o <= 8'h00;
      end
    end
  end
  // The debugger restoring patched bytes is a software duty
endmodule // bdu_core
`default_nettype wire

// ### design/bdu_map.vh
// Register numbers, field positions, reset values and codes of the breakpoint debug unit
`ifndef BDU_MAP_VH
`define BDU_MAP_VH
// Debug register numbers on the register port
`define BDU_REG_BP0 3'h0
`define BDU_REG_BP1 3'h1
`define BDU_REG_BP2 3'h2
`define BDU_REG_BP3 3'h3
`define BDU_REG_ALIAS_ST 3'h4
`define BDU_REG_ALIAS_CT 3'h5
`define BDU_REG_STATUS 3'h6
`define BDU_REG_CONTROL 3'h7
// Status field positions
`define BDU_ST_MATCH_LO 0
`define BDU_ST_BD 13
`define BDU_ST_BS 14
`define BDU_ST_BT 15
// Control field positions
`define BDU_CT_LEXACT 8
`define BDU_CT_GEXACT 9
`define BDU_CT_GUARD 13
`define BDU_CT_TYPE_LO 16
// Reset values
`define BDU_STATUS_RST 32'hFFFF0FF0
`define BDU_CONTROL_RST 32'h00000400
`define BDU_ADDR_RST 32'h00000000
// Bits of the status word that hardware keeps and software may clear
`define BDU_STATUS_LIVE 32'h0000E00F
// Control bits that are stored; the rest read as their reset value
`define BDU_CONTROL_LIVE 32'hFFFF23FF
// Type encodings
`define BDU_TYPE_EXEC 2'h0
`define BDU_TYPE_WRITE 2'h1
`define BDU_TYPE_IO 2'h2
`define BDU_TYPE_RDWR 2'h3
// Length encodings
`define BDU_LEN_1 2'h0
`define BDU_LEN_2 2'h1
`define BDU_LEN_4 2'h3
// Exception vectors and opcode
`define BDU_VEC_DEBUG 8'h01
`define BDU_VEC_BREAK 8'h03
`define BDU_OP_BREAK 8'hCC
`endif

// ### design/bdu_addr_regs.v
// Storage for the four breakpoint linear address registers
`timescale 1ns/1ps
`default_nettype none
`include "bdu_map.vh"
module bdu_addr_regs #(
  parameter WIDTH = 32
) (
  input wire mclk_i,
  input wire reset_i,
  input wire wr_i,
  input wire [1:0] wsel_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire [1:0] rsel_i,
  output reg [WIDTH-1:0] rdata_o,
  output wire [4*WIDTH-1:0] addr_all_o
);
  reg [WIDTH-1:0] mem_ff [0:3];
  integer i;

  // Write port and registered read port
  always @(posedge mclk_i) begin
    if (reset_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_ff[i] <= `BDU_ADDR_RST;
      end
      rdata_o <= `BDU_ADDR_RST;
    end else begin
      if (wr_i) begin
        mem_ff[wsel_i] <= wdata_i;
      end
      rdata_o <= mem_ff[rsel_i];
    end
  end

  // All four addresses go to the comparators at once
  assign addr_all_o = {mem_ff[3], mem_ff[2], mem_ff[1], mem_ff[0]};
endmodule // bdu_addr_regs
`default_nettype wire

// ### bench/bdu_core_asserts.sv
// Port checker for the breakpoint debug unit core
`timescale 1ns/1ps
`default_nettype none
module bdu_core_asserts (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic debug_extension_enable_i,
  input wire logic single_step_flag_i,
  input wire logic insn_done_i,
  input wire logic [7:0] insn_opcode_i,
  input wire logic dbg_reg_access_i,
  input wire logic task_switch_i,
  input wire logic task_trap_flag_i,
  input wire logic cyc_valid_i,
  input wire logic exc_fault_o,
  input wire logic exc_trap_o,
  input wire logic [7:0] exc_vector_o,
  input wire logic exc_undef_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Alias access seen by the port this cycle
  wire alias_acc = (reg_rd_i || reg_wr_i) && reg_addr_i[2:1] == 2'b10;
  rd_idle_zero_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000) else $error("read data not zero");
  alias_refuse_a: assert property (
    alias_acc && debug_extension_enable_i |=> exc_undef_o) else $error("no undefined opcode");
  undef_cause_a: assert property (
    exc_undef_o |-> $past(alias_acc && debug_extension_enable_i)) else $error("stray undef");
  alias_open_a: assert property (
    (reg_rd_i || reg_wr_i) && !debug_extension_enable_i |=> !exc_undef_o)
    else $error("undef with extension off");
  fault_vector_a: assert property (
    exc_fault_o |-> exc_vector_o == 8'h01 && !exc_trap_o) else $error("bad fault vector");
  idle_vector_a: assert property (
    !(exc_fault_o || exc_trap_o) |-> exc_vector_o == 8'h00) else $error("vector without pulse");
  break_insn_a: assert property (
    insn_done_i && insn_opcode_i == 8'hCC && !single_step_flag_i && !dbg_reg_access_i
    && !task_switch_i && !cyc_valid_i |=> exc_trap_o && exc_vector_o == 8'h03)
    else $error("no breakpoint trap");
  step_trap_a: assert property (
    insn_done_i && single_step_flag_i |=> exc_trap_o || exc_fault_o) else $error("no step trap");
  task_trap_a: assert property (
    task_switch_i && task_trap_flag_i |=> exc_trap_o || exc_fault_o) else $error("no task trap");
endmodule // bdu_core_asserts
bind bdu_core bdu_core_asserts CHK (.mclk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .debug_extension_enable_i, .single_step_flag_i, .insn_done_i, .insn_opcode_i,
  .dbg_reg_access_i, .task_switch_i, .task_trap_flag_i, .cyc_valid_i, .exc_fault_o,
  .exc_trap_o, .exc_vector_o, .exc_undef_o);
`default_nettype wire

// ### bench/bdu_cpu_model.sv
// Processor side model: instruction events and bus cycles
`timescale 1ns/1ps
`default_nettype none
module bdu_cpu_model (
  input wire logic mclk_i,
  output logic insn_done_o,
  output logic [7:0] insn_opcode_o,
  output logic dbg_reg_access_o,
  output logic task_switch_o,
  output logic task_trap_flag_o,
  output logic cyc_valid_o,
  output logic cyc_fetch_o,
  output logic cyc_write_o,
  output logic cyc_io_o,
  output logic [31:0] cyc_addr_o,
  output logic [1:0] cyc_size_o
);
  // Quiet at time zero
  initial begin
    {insn_done_o, insn_opcode_o, dbg_reg_access_o, task_switch_o, task_trap_flag_o} = '0;
    {cyc_valid_o, cyc_fetch_o, cyc_write_o, cyc_io_o, cyc_addr_o, cyc_size_o} = '0;
  end
  // One cycle: class is fetch, write, io
  task cyc(input logic [2:0] cls, input logic [31:0] a, input logic [1:0] sz);
    @(posedge mclk_i);
    {cyc_fetch_o, cyc_write_o, cyc_io_o} <= cls;
    cyc_addr_o <= a;
    cyc_size_o <= sz;
    cyc_valid_o <= 1'b1;
    @(posedge mclk_i);
    cyc_valid_o <= 1'b0;
    cyc_addr_o <= ~a; // Released bus must not look like a repeat hit
  endtask
  // Event bits: retire, register access, task switch, trap flag
  task ev(input logic [3:0] k, input logic [7:0] op);
    @(posedge mclk_i);
    {insn_done_o, dbg_reg_access_o, task_switch_o, task_trap_flag_o} <= k;
    insn_opcode_o <= op;
    @(posedge mclk_i);
    {insn_done_o, dbg_reg_access_o, task_switch_o} <= 3'h0;
    insn_opcode_o <= ~op;
  endtask
endmodule // bdu_cpu_model
`default_nettype wire

// ### bench/breakpoint_debug_unit_tb.sv
// Self-checking bench of the breakpoint debug unit
`timescale 1ns/1ps
`default_nettype none
module breakpoint_debug_unit_tb;
  logic mclk_i, reset_i, reg_wr_i, reg_rd_i, debug_extension_enable_i, single_step_flag_i;
  logic [2:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, cyc_addr_i;
  logic insn_done_i, dbg_reg_access_i, task_switch_i, task_trap_flag_i;
  logic cyc_valid_i, cyc_fetch_i, cyc_write_i, cyc_io_i;
  logic [7:0] insn_opcode_i, exc_vector_o;
  logic [1:0] cyc_size_i;
  logic exc_fault_o, exc_trap_o, exc_undef_o;
  int err_total, num_checks;
  bdu_core DUT (.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .debug_extension_enable_i, .single_step_flag_i, .insn_done_i,
    .insn_opcode_i, .dbg_reg_access_i, .task_switch_i, .task_trap_flag_i, .cyc_valid_i,
    .cyc_fetch_i, .cyc_write_i, .cyc_io_i, .cyc_addr_i, .cyc_size_i, .exc_fault_o,
    .exc_trap_o, .exc_vector_o, .exc_undef_o);
  bdu_cpu_model CPU (.mclk_i, .insn_done_o(insn_done_i), .insn_opcode_o(insn_opcode_i),
    .dbg_reg_access_o(dbg_reg_access_i), .task_switch_o(task_switch_i),
    .task_trap_flag_o(task_trap_flag_i), .cyc_valid_o(cyc_valid_i), .cyc_fetch_o(cyc_fetch_i),
    .cyc_write_o(cyc_write_i), .cyc_io_o(cyc_io_i), .cyc_addr_o(cyc_addr_i),
    .cyc_size_o(cyc_size_i));
  // ---------------------------------
  // Shared tasks
  // ---------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, reg_rdata_o, exp);
  endtask
  // Exception outputs as {fault, trap, vector}, one cycle after the cause
  task xc(input logic [9:0] exp, input string nm);
    #1 chk(nm, 32'({exc_fault_o, exc_trap_o, exc_vector_o}), 32'(exp));
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task t_reset;
    for (int i = 0; i < 4; i++) rd(i[2:0], 32'h00000000, "address reset");
    rd(3'h6, 32'hFFFF0FF0, "status reset");
    rd(3'h7, 32'h00000400, "control reset");
    wr(3'h3, 32'hA5C3_0001);
    rd(3'h3, 32'hA5C3_0001, "address readback");
    $display("reset test done");
  endtask
  task t_alias;
    wr(3'h5, 32'h00000300);
    rd(3'h7, 32'h00000700, "control via alias");
    rd(3'h4, 32'hFFFF0FF0, "status via alias");
    @(posedge mclk_i) debug_extension_enable_i <= 1'b1;
    rd(3'h4, 32'h00000000, "refused alias read");
    chk("undef on read", 32'(exc_undef_o), 32'h1);
    wr(3'h5, 32'h00002000);
    #1 chk("undef on write", 32'(exc_undef_o), 32'h1);
    rd(3'h7, 32'h00000700, "control kept");
    wr(3'h1, 32'h00000060);
    wr(3'h7, 32'h00200008);
    CPU.cyc(3'b001, 32'h00000060, 2'h0);
    xc(10'h101, "io trap");
    @(posedge mclk_i) debug_extension_enable_i <= 1'b0;
    wr(3'h6, 32'h00000000);
    $display("alias test done");
  endtask
  task t_data;
    wr(3'h0, 32'h00000100);
    wr(3'h1, 32'h00000100);
    wr(3'h7, 32'h00FF2002);
    CPU.cyc(3'b000, 32'h00000104, 2'h0);
    xc(10'h000, "miss above range");
    CPU.cyc(3'b000, 32'h000000FF, 2'h1);
    xc(10'h101, "overlap trap");
    rd(3'h6, 32'hFFFF0FF3, "both match bits");
    rd(3'h7, 32'h00FF0402, "guard cleared");
    wr(3'h6, 32'h00000000);
    wr(3'h7, 32'h00F00000);
    CPU.cyc(3'b000, 32'h00000100, 2'h0);
    xc(10'h000, "disabled match");
    rd(3'h6, 32'hFFFF0FF2, "disabled match bit");
    wr(3'h7, 32'h000D0002);
    CPU.cyc(3'b000, 32'h00000100, 2'h3);
    xc(10'h000, "read on write type");
    CPU.cyc(3'b010, 32'h00000101, 2'h1);
    xc(10'h101, "write trap");
    wr(3'h0, 32'h00000102);
    wr(3'h7, 32'h00070002);
    CPU.cyc(3'b000, 32'h00000101, 2'h0);
    xc(10'h000, "below two byte range");
    CPU.cyc(3'b000, 32'h00000103, 2'h0);
    xc(10'h101, "two byte range");
    wr(3'h6, 32'h00000000);
    $display("data test done");
  endtask
  task t_exec;
    wr(3'h2, 32'h00000200);
    wr(3'h3, 32'h00000300);
    wr(3'h7, 32'h00000390);
    CPU.cyc(3'b100, 32'h00000200, 2'h0);
    xc(10'h201, "exec fault");
    CPU.ev(4'b0011, 8'h00);
    xc(10'h101, "task trap");
    rd(3'h7, 32'h00000780, "local enables cleared");
    CPU.cyc(3'b100, 32'h00000300, 2'h0);
    xc(10'h201, "global survives");
    CPU.cyc(3'b100, 32'h00000200, 2'h0);
    xc(10'h000, "local gone");
    rd(3'h6, 32'hFFFF8FFC, "exec and task bits");
    wr(3'h6, 32'h00000000);
    $display("exec test done");
  endtask
  task t_step;
    @(posedge mclk_i) single_step_flag_i <= 1'b1;
    CPU.ev(4'b1000, 8'h90);
    xc(10'h101, "step trap");
    @(posedge mclk_i) single_step_flag_i <= 1'b0;
    CPU.ev(4'b1000, 8'hCC);
    xc(10'h103, "break opcode");
    CPU.ev(4'b1000, 8'h90);
    xc(10'h000, "restored byte");
    wr(3'h7, 32'h00002000);
    CPU.ev(4'b0100, 8'h00);
    xc(10'h201, "access fault");
    rd(3'h6, 32'hFFFF6FF0, "step and access bits");
    rd(3'h7, 32'h00000400, "guard cleared");
    $display("step test done");
  endtask
  // Clock and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    #100000;
    err_total++;
    summarize;
  end
  // Main sequence
  initial begin
    {reg_wr_i, reg_rd_i, debug_extension_enable_i, single_step_flag_i} = 4'h0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 32'h00000000;
    reset_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset;
    t_alias;
    t_data;
    t_exec;
    t_step;
    summarize;
  end
endmodule // breakpoint_debug_unit_tb
`default_nettype wire
